// ===== logic/clock_synth_pkg.sv
/*
 * Shared constants for the clock synthesizer configuration bank: slave
 * address, register offsets, field positions, reset value, link states.
 * Assumes 8-bit register addresses and 8-bit register data throughout.
 */
package clock_synth_pkg;

    localparam logic [6:0] SLAVE_ADDR = 7'h69; // 1101001
    localparam logic [7:0] REG_RESET = 8'h00;

    // register offsets
    localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h09;
    localparam logic [7:0] OFS_BANK1 = 8'h0c;
    localparam logic [7:0] OFS_OSC_DRIVE = 8'h12;
    localparam logic [7:0] OFS_LOAD_CAP = 8'h13;
    localparam logic [7:0] OFS_PUMP_FB_HIGH = 8'h40;
    localparam logic [7:0] OFS_FB_LOW = 8'h41;
    localparam logic [7:0] OFS_ODD_REF_DIV = 8'h42;
    localparam logic [7:0] OFS_SRC_SEL_0 = 8'h44;
    localparam logic [7:0] OFS_SRC_SEL_1 = 8'h45;
    localparam logic [7:0] OFS_SRC_SEL_2 = 8'h46;
    localparam logic [7:0] OFS_BANK2 = 8'h47;

    localparam int NUM_REGS = 11;

    // field positions
    localparam int FLAG_BIT = 7;       // source select or odd bit
    localparam int DIVISOR_MSB = 6;
    localparam int DRIVE_MSB = 4;
    localparam int DRIVE_LSB = 3;
    localparam int PUMP_MSB = 4;
    localparam int PUMP_LSB = 2;
    localparam int FB_HIGH_MSB = 1;
    localparam int ENABLE_MSB = 5;
    localparam int SRC_TAIL_LSB = 6;   // low two bits of the last output's select in the third byte

    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
        ST_DATA, ST_ACK_DATA, ST_READ, ST_READ_ACK
    } link_state_t;

    // slot of a mapped register in the readback copy
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [3:0] idx;
        idx = 4'h0;
        if (a == OFS_OUTPUT_ENABLE) idx = 4'h0;
        else if (a == OFS_BANK1) idx = 4'h1;
        else if (a == OFS_OSC_DRIVE) idx = 4'h2;
        else if (a == OFS_LOAD_CAP) idx = 4'h3;
        else if (a == OFS_PUMP_FB_HIGH) idx = 4'h4;
        else if (a == OFS_FB_LOW) idx = 4'h5;
        else if (a == OFS_ODD_REF_DIV) idx = 4'h6;
        else if (a == OFS_SRC_SEL_0) idx = 4'h7;
        else if (a == OFS_SRC_SEL_1) idx = 4'h8;
        else if (a == OFS_SRC_SEL_2) idx = 4'h9;
        else idx = 4'ha;
        return idx;
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == OFS_OUTPUT_ENABLE) || (a == OFS_BANK1) ||
            (a == OFS_OSC_DRIVE) || (a == OFS_LOAD_CAP) ||
            (a == OFS_PUMP_FB_HIGH) || (a == OFS_FB_LOW) ||
            (a == OFS_ODD_REF_DIV) || (a == OFS_SRC_SEL_0) ||
            (a == OFS_SRC_SEL_1) || (a == OFS_SRC_SEL_2) ||
            (a == OFS_BANK2);
    endfunction

endpackage

// ===== logic/cfg_write_if.sv
/*
 * Carrier for the write event that crosses from the serial link domain
 * into the core clock domain. The toggle flips once per accepted write.
 */
`timescale 1ns/1ps
interface cfg_write_if;
    logic toggle;  // link clock domain
    logic commit;  // core clock domain, one-cycle pulse
    modport link (output toggle);
    modport sync (input toggle, output commit);
    modport core (input commit);
endinterface

// ===== logic/start_detect.sv
/*
 * Start condition detector: serial data falling while the serial clock
 * is high. Assumes the master keeps data stable while the clock is high
 * except to signal start or stop, and a hold time before the clock falls.
 */
`timescale 1ns/1ps
module start_detect (
    input wire logic i_rstn,
    input wire logic i_sda,
    input wire logic i_scl,
    output logic o_start_toggle
);
    // flips on each start; the link side compares it at the next clock rise,
    // which the start hold time puts well after this edge
    always_ff @(negedge i_sda or negedge i_rstn) begin
        if (!i_rstn) begin
            o_start_toggle <= 1'b0;
        end else if (i_scl) begin
            o_start_toggle <= ~o_start_toggle;
        end
    end
endmodule

// ===== logic/event_sync.sv
/*
 * Toggle synchroniser: brings the link write toggle into the core clock
 * domain through two flip-flops and turns each change into one pulse.
 * Assumes toggles are spaced far more than three core clocks apart.
 */
`timescale 1ns/1ps
module event_sync (
    input wire logic i_clk,
    input wire logic i_rstn,
    cfg_write_if.sync bus
);
    logic meta;
    logic stable;
    logic seen;

    // first stage is read only by the second
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta <= 1'b0;
            stable <= 1'b0;
            seen <= 1'b0;
        end else begin
            meta <= bus.toggle;
            stable <= meta;
            seen <= stable;
        end
    end

    assign bus.commit = stable ^ seen;
endmodule

// ===== logic/clock_synth_config_registers.sv
/*
 * Volatile configuration register bank of a one-PLL clock synthesizer,
 * written and read over a two-wire serial link. The link logic runs on the
 * serial clock; the registers that steer the synthesizer run on i_clk.
 * Assumes the master follows the two-wire protocol: data stable while the
 * serial clock is high, and the serial clock still between frames.
 */
`timescale 1ns/1ps

// How it works
// [RULE1] registers volatile, cleared on every power-up
// [RULE2] eight-bit register address, eight data bits
// [RULE3] slave only, answers address 69h only
// [RULE4] drive code in bits 4..3 of 12h
// [RULE5] host writes 12h reserved bits fixed
// [RULE6] host picks drive code by reference frequency
// [RULE7] host picks crystal drive code from table
// [RULE8] load capacitance code fills register 13h
// [RULE9] host computes load capacitance code
// [RULE10] host leaves load code zero for clocks
// [RULE11] 0ch: bank one source flag, divisor
// [RULE12] 47h: bank two source flag, divisor
// [RULE13] 42h: feedback odd bit, reference divisor
// [RULE14] six three-bit source selects across 44h-46h
// [RULE15] feedback count 40h[1:0], 41h; pump 40h[4:2]
// [RULE16] output enabled only by its 09h bit
// [RULE17] unprogrammed: all bits zero, outputs off
// [RULE18] write: address, register byte, one data byte
// [RULE19] new value acts after acknowledged data byte
module clock_synth_config_registers
    import clock_synth_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic [1:0] o_osc_drive_code,
    output logic [7:0] o_load_cap_code,
    output logic o_bank1_source_select,
    output logic [6:0] o_bank1_divisor,
    output logic o_bank2_source_select,
    output logic [6:0] o_bank2_divisor,
    output logic [9:0] o_feedback_base_count,
    output logic [2:0] o_charge_pump,
    output logic o_feedback_odd_bit,
    output logic [6:0] o_ref_divisor,
    output logic [17:0] o_output_source_select,
    output logic [5:0] o_output_enable_bits
);

    // link clock domain state
    link_state_t state;
    logic [2:0] bit_count;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] reg_ptr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic ack_ok;
    logic read_dir;
    logic start_toggle;
    logic start_seen;
    logic start_now;
    logic [7:0] shadow [NUM_REGS];

    // core clock domain registers
    logic [7:0] output_enable_ctrl;
    logic [7:0] bank1_source_and_divisor;
    logic [7:0] oscillator_drive_ctrl;
    logic [7:0] load_capacitance_ctrl;
    logic [7:0] pump_and_feedback_high;
    logic [7:0] feedback_low;
    logic [7:0] odd_bit_and_ref_divisor;
    logic [7:0] output_source_sel_0;
    logic [7:0] output_source_sel_1;
    logic [7:0] output_source_sel_2;
    logic [7:0] bank2_source_and_divisor;

    cfg_write_if wr_bus ();

    start_detect u_start (
        .i_rstn(i_rstn),
        .i_sda(i_sda_in),
        .i_scl(i_scl),
        .o_start_toggle(start_toggle)
    );

    event_sync u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .bus(wr_bus.sync)
    );

    // a start seen since the last rising edge restarts any transfer
    assign start_now = start_toggle ^ start_seen;

    // receive side: bits are taken on the rising serial clock
    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
            bit_count <= 3'h0;
            rx <= REG_RESET;
            tx <= REG_RESET;
            reg_ptr <= REG_RESET;
            ack_ok <= 1'b0;
            read_dir <= 1'b0;
            start_seen <= 1'b0;
        end else if (start_now) begin
            // the first rise after a start carries the address msb
            start_seen <= start_toggle;
            state <= ST_ADDR;
            rx <= {7'h00, i_sda_in};
            bit_count <= 3'h1;
            ack_ok <= 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    rx <= {rx[6:0], i_sda_in};
                    bit_count <= bit_count + 3'h1;
                    if (bit_count == LAST_BIT) begin
                        ack_ok <= (rx[6:0] == SLAVE_ADDR); // see [RULE3]
                        read_dir <= i_sda_in;
                        state <= ST_ACK_ADDR;
                    end
                end
                ST_ACK_ADDR: begin
                    bit_count <= 3'h0;
                    if (!ack_ok) begin
                        state <= ST_IDLE; // other slaves: stay silent
                    end else if (read_dir) begin
                        tx <= shadow[reg_index(reg_ptr)];
                        state <= ST_READ;
                    end else begin
                        state <= ST_REG;
                    end
                end
                ST_REG: begin
                    rx <= {rx[6:0], i_sda_in};
                    bit_count <= bit_count + 3'h1;
                    if (bit_count == LAST_BIT) begin
                        // unmapped offsets are refused to avoid test modes
                        ack_ok <= reg_mapped({rx[6:0], i_sda_in}); // see [RULE2]
                        state <= ST_ACK_REG;
                    end
                end
                ST_ACK_REG: begin
                    bit_count <= 3'h0;
                    if (ack_ok) begin
                        reg_ptr <= rx; // see [RULE2]
                        state <= ST_DATA;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_DATA: begin
                    rx <= {rx[6:0], i_sda_in};
                    bit_count <= bit_count + 3'h1;
                    if (bit_count == LAST_BIT) begin
                        ack_ok <= 1'b1;
                        state <= ST_ACK_DATA;
                    end
                end
                ST_ACK_DATA: begin
                    // one data byte per write; further bytes are not acked
                    state <= ST_IDLE; // see [RULE18]
                end
                ST_READ: begin
                    bit_count <= bit_count + 3'h1;
                    if (bit_count == LAST_BIT) begin
                        state <= ST_READ_ACK;
                    end
                end
                ST_READ_ACK: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // write event: data and address stay put until the next write, which
    // is at least a full frame later, so the core can sample them directly
    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_bus.toggle <= 1'b0;
            wr_addr <= REG_RESET;
            wr_data <= REG_RESET;
        end else if (!start_now && state == ST_ACK_DATA) begin
            wr_addr <= reg_ptr;
            wr_data <= rx;
            wr_bus.toggle <= ~wr_bus.toggle; // see [RULE18] [RULE19]
        end
    end

    // readback copy kept in the link domain so reads need no crossing
    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                shadow[i] <= REG_RESET;
            end
        end else if (!start_now && state == ST_ACK_DATA) begin
            shadow[reg_index(reg_ptr)] <= rx;
        end
    end

    // drive side: the data line changes only while the serial clock is low
    always_ff @(negedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
        end else begin
            o_sda_out <= 1'b0; // open drain: only ever pulls low
            case (state)
                ST_ACK_ADDR, ST_ACK_REG, ST_ACK_DATA: begin
                    o_sda_oe <= ack_ok; // see [RULE18]
                end
                ST_READ: begin
                    o_sda_oe <= ~tx[~bit_count]; // msb first
                end
                default: begin
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // core register file: written only when the crossed event arrives,
    // so nothing changes before the byte is acknowledged
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            output_enable_ctrl <= REG_RESET; // see [RULE17] [RULE1]
            bank1_source_and_divisor <= REG_RESET;
            oscillator_drive_ctrl <= REG_RESET;
            load_capacitance_ctrl <= REG_RESET;
            pump_and_feedback_high <= REG_RESET;
            feedback_low <= REG_RESET;
            odd_bit_and_ref_divisor <= REG_RESET;
            output_source_sel_0 <= REG_RESET;
            output_source_sel_1 <= REG_RESET;
            output_source_sel_2 <= REG_RESET;
            bank2_source_and_divisor <= REG_RESET;
        end else if (wr_bus.commit) begin // see [RULE19]
            if (wr_addr == OFS_OUTPUT_ENABLE) begin
                output_enable_ctrl <= wr_data;
            end else if (wr_addr == OFS_BANK1) begin
                bank1_source_and_divisor <= wr_data;
            end else if (wr_addr == OFS_OSC_DRIVE) begin
                oscillator_drive_ctrl <= wr_data;
            end else if (wr_addr == OFS_LOAD_CAP) begin
                load_capacitance_ctrl <= wr_data;
            end else if (wr_addr == OFS_PUMP_FB_HIGH) begin
                pump_and_feedback_high <= wr_data;
            end else if (wr_addr == OFS_FB_LOW) begin
                feedback_low <= wr_data;
            end else if (wr_addr == OFS_ODD_REF_DIV) begin
                odd_bit_and_ref_divisor <= wr_data;
            end else if (wr_addr == OFS_SRC_SEL_0) begin
                output_source_sel_0 <= wr_data;
            end else if (wr_addr == OFS_SRC_SEL_1) begin
                output_source_sel_1 <= wr_data;
            end else if (wr_addr == OFS_SRC_SEL_2) begin
                output_source_sel_2 <= wr_data;
            end else if (wr_addr == OFS_BANK2) begin
                bank2_source_and_divisor <= wr_data;
            end
        end
    end

    // field views; each bit is a register bit, so outputs stay flop-driven
    assign o_osc_drive_code = oscillator_drive_ctrl[DRIVE_MSB:DRIVE_LSB]; // see [RULE4]
    assign o_load_cap_code = load_capacitance_ctrl; // see [RULE8]
    assign o_bank1_source_select = bank1_source_and_divisor[FLAG_BIT]; // see [RULE11]
    assign o_bank1_divisor = bank1_source_and_divisor[DIVISOR_MSB:0];
    assign o_bank2_source_select = bank2_source_and_divisor[FLAG_BIT]; // see [RULE12]
    assign o_bank2_divisor = bank2_source_and_divisor[DIVISOR_MSB:0];
    assign o_feedback_base_count = {pump_and_feedback_high[FB_HIGH_MSB:0],
        feedback_low}; // see [RULE15]
    assign o_charge_pump = pump_and_feedback_high[PUMP_MSB:PUMP_LSB];
    assign o_feedback_odd_bit = odd_bit_and_ref_divisor[FLAG_BIT]; // see [RULE13]
    assign o_ref_divisor = odd_bit_and_ref_divisor[DIVISOR_MSB:0];
    // output one's select sits in the top three bits, msb first
    assign o_output_source_select = {output_source_sel_0, output_source_sel_1,
        output_source_sel_2[FLAG_BIT:SRC_TAIL_LSB]}; // see [RULE14]
    assign o_output_enable_bits = output_enable_ctrl[ENABLE_MSB:0]; // see [RULE16]

endmodule

// ===== tb/clock_synth_sva.sv
/* Port checker for the config bank, bound to its top module.
   Assumes a pulled-up data wire and frames that open with a start. */
`timescale 1ns/1ps
module clock_synth_sva (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda_in,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [1:0] o_osc_drive_code,
    input wire logic [7:0] o_load_cap_code,
    input wire logic o_bank1_source_select,
    input wire logic [6:0] o_bank1_divisor,
    input wire logic o_bank2_source_select,
    input wire logic [6:0] o_bank2_divisor,
    input wire logic [9:0] o_feedback_base_count,
    input wire logic [2:0] o_charge_pump,
    input wire logic o_feedback_odd_bit,
    input wire logic [6:0] o_ref_divisor,
    input wire logic [17:0] o_output_source_select,
    input wire logic [5:0] o_output_enable_bits
);
    logic start_tgl, seen_tgl, scl_q;
    logic [3:0] bitn, nbyte, quiet;
    logic [7:0] sh;
    wire logic [70:0] cfg = {o_osc_drive_code, o_load_cap_code, o_bank1_source_select,
        o_bank1_divisor, o_bank2_source_select, o_bank2_divisor, o_feedback_base_count,
        o_charge_pump, o_feedback_odd_bit, o_ref_divisor, o_output_source_select,
        o_output_enable_bits};

    // start: data falls while the clock is high
    always_ff @(negedge i_sda_in or negedge i_rstn) begin
        if (!i_rstn) start_tgl <= 1'b0;
        else if (i_scl) start_tgl <= ~start_tgl;
    end

    // bit and byte position in the frame; a toggle avoids two drivers
    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            seen_tgl <= 1'b0;
            bitn <= 4'h0;
            nbyte <= 4'h0;
            sh <= 8'h00;
        end else if (seen_tgl != start_tgl) begin
            seen_tgl <= start_tgl;
            bitn <= 4'h1;
            nbyte <= 4'h0;
            sh <= {7'h00, i_sda_in};
        end else if (bitn == 4'h8) begin
            bitn <= 4'h0;
            nbyte <= (nbyte == 4'hf) ? nbyte : nbyte + 4'h1;
        end else begin
            bitn <= bitn + 4'h1;
            sh <= {sh[6:0], i_sda_in};
        end
    end

    // core clocks since the serial clock last moved
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_q <= 1'b1;
            quiet <= 4'h0;
        end else begin
            scl_q <= i_scl;
            quiet <= (i_scl != scl_q) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
        end
    end

    reset_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(i_rstn) |-> cfg == 71'h0) else $error("config not clear after reset");
    open_drain_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_sda_out == 1'b0) else $error("data driven high");
    addr_ack_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        bitn == 4'h8 && nbyte == 4'h0 |-> o_sda_oe == (sh[7:1] == 7'h69))
        else $error("address acknowledge wrong");
    extra_nack_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        bitn == 4'h8 && nbyte >= 4'h3 |-> !o_sda_oe) else $error("extra byte acknowledged");
    quiet_stable_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        quiet >= 4'h6 |-> $stable(cfg)) else $error("config moved without link traffic");
    fb_split_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $changed(o_feedback_base_count[7:0]) |->
        $stable(o_feedback_base_count[9:8]) && $stable(o_charge_pump))
        else $error("feedback low write leaked");
    src_split_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $changed(o_output_source_select[9:2]) |->
        $stable({o_output_source_select[17:10], o_output_source_select[1:0]}))
        else $error("source select write leaked");
    enable_only_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $changed(o_output_enable_bits) |-> $stable(cfg[70:6])) else $error("enable write leaked");
endmodule

bind clock_synth_config_registers clock_synth_sva u_sva (
    .i_clk, .i_rstn, .i_scl, .i_sda_in, .o_sda_out, .o_sda_oe,
    .o_osc_drive_code, .o_load_cap_code, .o_bank1_source_select, .o_bank1_divisor,
    .o_bank2_source_select, .o_bank2_divisor, .o_feedback_base_count, .o_charge_pump,
    .o_feedback_odd_bit, .o_ref_divisor, .o_output_source_select, .o_output_enable_bits
);

// ===== tb/serial_host_model.sv
/* Two-wire bus master: makes the 64 ns serial clock, pulls the data wire.
   Assumes a pull-up on the wire; the clock stands high between frames. */
`timescale 1ns/1ps
module serial_host_model (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    // idle bus: clock high, data released
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end

    // start or repeated start: data falls while the clock is high
    task automatic start_cond();
        if (!o_scl) begin
            #8 o_sda_pull = 1'b0;
            #24 o_scl = 1'b1;
        end
        #16 o_sda_pull = 1'b1;
        #16 o_scl = 1'b0;
    endtask

    // data changes only in the low phase, so it never fakes a start or stop
    task automatic clk_bit(input logic pull, output logic seen);
        #8 o_sda_pull = pull;
        #24 o_scl = 1'b1;
        #16 seen = i_sda;
        #16 o_scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(~b[i], s);
        clk_bit(1'b0, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b0, b[i]);
        clk_bit(ack_it, s);
    endtask

    task automatic stop_cond();
        #8 o_sda_pull = 1'b1;
        #24 o_scl = 1'b1;
        #16 o_sda_pull = 1'b0;
        #16;
    endtask

    // slave address with write direction, offset, one data byte
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
        input logic [7:0] val, output logic [2:0] acks);
        start_cond();
        send_byte({dev, 1'b0}, acks[2]);
        send_byte(ofs, acks[1]);
        send_byte(val, acks[0]);
        stop_cond();
    endtask

    // pointer set by a write without data, then one byte read and refused
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
        output logic [7:0] val);
        logic a;
        start_cond();
        send_byte({dev, 1'b0}, a);
        send_byte(ofs, a);
        start_cond();
        send_byte({dev, 1'b1}, a);
        recv_byte(1'b0, val);
        stop_cond();
    endtask
endmodule

// ===== tb/clock_synth_config_registers_tb.sv
/* Self-checking bench for the config bank: a host model writes and reads
   registers over the link; assumes a 20 MHz core clock. */
`timescale 1ns/1ps
module clock_synth_config_registers_tb;
    logic i_clk = 1'b0;
    // starts unknown so the time-zero drop is a real edge for async resets
    logic i_rstn;
    wire logic scl, host_pull, sda_out, sda_oe;
    wire logic [70:0] cfg;
    wire logic sda = (sda_oe ? sda_out : 1'b1) & ~host_pull;
    int n_fail = 0;
    int check_count = 0;
    logic [7:0] regs [11];
    // offsets in readback order, one legal value each (crystal setup)
    logic [7:0] ofs_tab [11] = '{8'h09, 8'h0c, 8'h12, 8'h13, 8'h40, 8'h41, 8'h42,
        8'h44, 8'h45, 8'h46, 8'h47};
    logic [7:0] val_tab [11] = '{8'h2a, 8'h8d, 8'h30, 8'ha7, 8'hd3, 8'h5a, 8'h9b,
        8'hc5, 8'h3c, 8'hbf, 8'h0e};

    always #25 i_clk = ~i_clk;

    clock_synth_config_registers u_dut (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_scl(scl),
        .i_sda_in(sda),
        .o_sda_out(sda_out),
        .o_sda_oe(sda_oe),
        .o_osc_drive_code(cfg[70:69]),
        .o_load_cap_code(cfg[68:61]),
        .o_bank1_source_select(cfg[60]),
        .o_bank1_divisor(cfg[59:53]),
        .o_bank2_source_select(cfg[52]),
        .o_bank2_divisor(cfg[51:45]),
        .o_feedback_base_count(cfg[44:35]),
        .o_charge_pump(cfg[34:32]),
        .o_feedback_odd_bit(cfg[31]),
        .o_ref_divisor(cfg[30:24]),
        .o_output_source_select(cfg[23:6]),
        .o_output_enable_bits(cfg[5:0])
    );

    serial_host_model u_host (
        .i_sda(sda),
        .o_scl(scl),
        .o_sda_pull(host_pull)
    );

    task automatic chk(input logic [70:0] got, input logic [70:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // all fields in port order, built from the stored register images
    function automatic logic [70:0] exp_cfg();
        return {regs[2][4:3], regs[3], regs[1], regs[10], regs[4][1:0], regs[5],
            regs[4][4:2], regs[6], regs[7], regs[8], regs[9][7:6], regs[0][5:0]};
    endfunction

    // the commit lands a few core clocks after the last acknowledge
    task automatic settle();
        repeat (6) @(posedge i_clk);
        #1;
    endtask

    task automatic t_write_all();
        logic [2:0] acks;
        foreach (regs[i]) regs[i] = 8'h00;
        chk(cfg, exp_cfg());
        for (int i = 0; i < 11; i++) begin
            u_host.write_reg(7'h69, ofs_tab[i], val_tab[i], acks);
            chk(71'(acks), 71'h7);
            regs[i] = val_tab[i];
            settle();
            chk(cfg, exp_cfg());
            chk(cfg, exp_cfg());
        end
    endtask

    // another slave, then a reserved offset: refused, nothing stored
    task automatic t_refused();
        logic [2:0] acks;
        u_host.write_reg(7'h45, 8'h13, 8'h11, acks);
        chk(71'(acks), 71'h0);
        u_host.write_reg(7'h69, 8'h43, 8'h55, acks);
        chk(71'(acks[2:1]), 71'h2);
        settle();
        chk(cfg, exp_cfg());
    endtask

    // a second data byte in one write is refused and dropped
    task automatic t_extra_byte();
        logic a0, a1, a2, a3;
        u_host.start_cond();
        u_host.send_byte(8'hd2, a0);
        u_host.send_byte(8'h13, a1);
        u_host.send_byte(8'h3c, a2);
        u_host.send_byte(8'hc3, a3);
        u_host.stop_cond();
        chk(71'({a0, a1, a2, a3}), 71'he);
        regs[3] = 8'h3c;
        settle();
        chk(cfg, exp_cfg());
    endtask

    task automatic t_read_back();
        logic [7:0] v;
        u_host.read_reg(7'h69, 8'h42, v);
        chk(71'(v), 71'(regs[6]));
    endtask

    // power loss clears everything; host reprograms for an external clock
    task automatic t_power_cycle();
        logic [2:0] acks;
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        foreach (regs[i]) regs[i] = 8'h00;
        settle();
        chk(cfg, exp_cfg());
        u_host.write_reg(7'h69, 8'h12, 8'h38, acks);
        regs[2] = 8'h38;
        settle();
        chk(cfg, exp_cfg());
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        i_rstn <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        settle();
        t_write_all();
        t_refused();
        t_extra_byte();
        t_read_back();
        t_power_cycle();
        close_out();
    end

    // hang guard: the run needs well under 100 us
    initial begin
        #300000;
        n_fail++;
        close_out();
    end
endmodule
